// ---- hw/config_regs_pkg.sv ----
`default_nettype none
package config_regs_pkg;

  // ********************************************
  // register indices
  // ********************************************
  localparam logic [7:0] IDX_RATE_TABLE = 8'h0b;
  localparam logic [7:0] IDX_SERIAL_MODE = 8'h0c;
  localparam logic [7:0] IDX_PART_IDENT = 8'h0d;
  localparam logic [7:0] IDX_SILICON_REV = 8'h0e;
  localparam logic [7:0] IDX_TEST_BITS = 8'h0f;
  localparam logic [7:0] IDX_CLOCK_GEN = 8'h10;
  localparam logic [7:0] IDX_LOOPBACK = 8'h11;

  // ********************************************
  // reset values and fixed codes
  // ********************************************
  localparam logic [7:0] RESET_ZERO = 8'h00;
  localparam logic [7:0] PART_IDENT_CODE = 8'h5a; // arbitrary value
  localparam logic [7:0] SILICON_REV_CODE = 8'h17; // arbitrary value
  localparam logic       SERIAL_OUT_IDLE = 1'h1; // line rests at mark
  localparam logic [3:0] DIV_COUNT_START = 4'h0;

  // ********************************************
  // field positions
  // ********************************************
  localparam int RATE_TABLE_SEL_LO = 0; // low bit of each drive pair
  localparam int RATE_TABLE_SEL_HI = 1; // high bit of each drive pair
  localparam int SM_RX_INVERT = 0;
  localparam int SM_TX_INVERT = 1;
  localparam int SM_HALF_DUPLEX = 2;
  localparam int SM_MODE_LSB = 3;
  localparam int SM_UART1_FAST = 6;
  localparam int SM_UART2_FAST = 7;
  localparam int CG_PLL_GAIN_DOUBLE = 3;
  localparam int CG_PLL_HALT = 4;
  localparam int CG_DIVIDER_HALT = 5;
  localparam int CG_PLL_INPUT_24M = 6;
  localparam int CG_IR_TEST = 7;
  localparam logic [7:0] CG_WRITE_MASK = 8'hf8;
  localparam logic [7:0] LB_WRITE_MASK = 8'h03;
  localparam int LB_IR_LOOPBACK = 0;
  localparam int LB_FDC_TIMEOUT_TEST = 1;

  // ********************************************
  // serial port 2 modes and divider counts
  // ********************************************
  typedef enum logic [2:0] {
    MODE_STANDARD = 3'h0,
    MODE_IRDA     = 3'h1,
    MODE_ASK_IR   = 3'h2
  } uart2_mode_e;
  localparam logic [3:0] DIV_TWELVE_LAST = 4'hb;
  localparam logic [3:0] DIV_THIRTEEN_LAST = 4'hc;

endpackage
`default_nettype wire

// ---- hw/config_regs_uart_pll_id.sv ----
`timescale 1ns/1ps
`default_nettype none
module config_regs_uart_pll_id (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       cfgMode,
  input  wire logic       indexWe,
  input  wire logic       dataWe,
  input  wire logic       dataRe,
  input  wire logic [7:0] wrData,
  input  wire logic       uart2RxPin,
  input  wire logic       uart2TxCore,
  input  wire logic       serialDivBy13,
  output logic      [7:0] rdData,
  output logic            rdValid,
  output logic      [7:0] indexValue,
  output logic      [1:0] driveZeroRate,
  output logic      [1:0] driveOneRate,
  output logic      [1:0] driveTwoRate,
  output logic      [1:0] driveThreeRate,
  output logic            uart2RxCore,
  output logic            serialOutPin,
  output logic            uart2HalfDuplex,
  output logic      [2:0] uart2Mode,
  output logic            uart2ModeIrda,
  output logic            uart2ModeAsk,
  output logic            uart1HighSpeed,
  output logic            uart2HighSpeed,
  output logic      [7:0] testBitsOut,
  output logic            pllGainDouble,
  output logic            pllHalt,
  output logic            serialClkDividerHalt,
  output logic            pllInput24m,
  output logic            irTestRoute,
  output logic            irLoopback,
  output logic            fdcTimeoutTest,
  output logic            uartClkEn
);

  // ********************************************
  // state
  // ********************************************
  typedef struct packed {
    logic [7:0] idx;
    logic [7:0] rateTable;
    logic [7:0] serialMode;
    logic [7:0] testBits;
    logic [7:0] clockGen;
    logic [7:0] loopback;
    logic [7:0] rdData;
    logic       rdValid;
    logic       rxCore;
    logic       serialOut;
    logic [3:0] divCnt;
    logic       divPulse;
  } state_s;

  state_s q;
  state_s d;

  // read mux; unmapped indices answer zero
  function automatic logic [7:0] readReg(input state_s s);
    logic [7:0] v;
    v = 8'h00;
    case (s.idx)
      config_regs_pkg::IDX_RATE_TABLE:  v = s.rateTable;
      config_regs_pkg::IDX_SERIAL_MODE: v = s.serialMode;
      config_regs_pkg::IDX_PART_IDENT:  v = config_regs_pkg::PART_IDENT_CODE;
      config_regs_pkg::IDX_SILICON_REV: v = config_regs_pkg::SILICON_REV_CODE;
      config_regs_pkg::IDX_TEST_BITS:   v = s.testBits;
      config_regs_pkg::IDX_CLOCK_GEN:   v = s.clockGen & config_regs_pkg::CG_WRITE_MASK;
      config_regs_pkg::IDX_LOOPBACK:    v = s.loopback & config_regs_pkg::LB_WRITE_MASK;
      default:                          v = 8'h00;
    endcase
    return v;
  endfunction

  // ********************************************
  // next state
  // ********************************************
  // a data access in the same cycle as an index write uses the old index
  always_comb begin
    logic [3:0] divLast;
    divLast = 4'h0;
    d = q;
    d.rdValid = 1'b0;
    if (cfgMode && indexWe) begin
      d.idx = wrData;
    end
    // register writes only in config mode, steered by the index
    if (cfgMode && dataWe) begin
      case (q.idx)
        config_regs_pkg::IDX_RATE_TABLE:  d.rateTable = wrData;
        config_regs_pkg::IDX_SERIAL_MODE: d.serialMode = wrData;
        config_regs_pkg::IDX_TEST_BITS:   d.testBits = wrData;
        config_regs_pkg::IDX_CLOCK_GEN: begin
          d.clockGen = wrData & config_regs_pkg::CG_WRITE_MASK;
        end
        config_regs_pkg::IDX_LOOPBACK: begin
          d.loopback = wrData & config_regs_pkg::LB_WRITE_MASK;
        end
        default: d.idx = d.idx; // ident, revision, unmapped: no effect
      endcase
    end
    // reads also only in config mode
    if (cfgMode && dataRe) begin
      d.rdValid = 1'b1;
      d.rdData = readReg(q);
    end
    // polarity applied on the port 2 receive path
    d.rxCore = uart2RxPin ^ q.serialMode[config_regs_pkg::SM_RX_INVERT];
    // ir test shows both directions on the pin, combined as a wired-and
    if (q.clockGen[config_regs_pkg::CG_IR_TEST]) begin
      d.serialOut = uart2RxPin & uart2TxCore;
    end else begin
      d.serialOut = uart2TxCore ^ q.serialMode[config_regs_pkg::SM_TX_INVERT];
    end
    // divide by 12 or 13 enable; held in reset while halted
    divLast = serialDivBy13 ? config_regs_pkg::DIV_THIRTEEN_LAST
                            : config_regs_pkg::DIV_TWELVE_LAST;
    if (q.clockGen[config_regs_pkg::CG_DIVIDER_HALT]) begin
      d.divCnt = 4'h0;
      d.divPulse = 1'b0;
    end else if (q.divCnt >= divLast) begin
      d.divCnt = 4'h0;
      d.divPulse = 1'b1;
    end else begin
      d.divCnt = q.divCnt + 4'h1;
      d.divPulse = 1'b0;
    end
  end

  // ********************************************
  // registers
  // ********************************************
  // power-up and hardware reset share one reset input
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q.idx <= config_regs_pkg::RESET_ZERO;
      q.rateTable <= config_regs_pkg::RESET_ZERO;
      q.serialMode <= config_regs_pkg::RESET_ZERO;
      q.testBits <= config_regs_pkg::RESET_ZERO;
      q.clockGen <= config_regs_pkg::RESET_ZERO;
      q.loopback <= config_regs_pkg::RESET_ZERO;
      q.rdData <= config_regs_pkg::RESET_ZERO;
      q.rdValid <= 1'h0;
      q.rxCore <= 1'h0;
      q.serialOut <= config_regs_pkg::SERIAL_OUT_IDLE;
      q.divCnt <= config_regs_pkg::DIV_COUNT_START;
      q.divPulse <= 1'h0;
    end else begin
      q <= d;
    end
  end

  // ********************************************
  // outputs
  // ********************************************
  // drive pairs, drive zero in the lowest pair
  assign driveZeroRate = q.rateTable[1:0];
  assign driveOneRate = q.rateTable[3:2];
  assign driveTwoRate = q.rateTable[5:4];
  assign driveThreeRate = q.rateTable[7:6];

  // register readback and the live index
  assign rdData = q.rdData;
  assign rdValid = q.rdValid;
  assign indexValue = q.idx;

  // serial port controls
  assign uart2RxCore = q.rxCore;
  assign serialOutPin = q.serialOut;
  assign uart2HalfDuplex = q.serialMode[config_regs_pkg::SM_HALF_DUPLEX];
  assign uart2Mode = q.serialMode[config_regs_pkg::SM_MODE_LSB +: 3];
  // reserved mode codes fall back to neither infrared flag
  assign uart2ModeIrda = (uart2Mode == config_regs_pkg::MODE_IRDA);
  assign uart2ModeAsk = (uart2Mode == config_regs_pkg::MODE_ASK_IR);
  assign uart1HighSpeed = q.serialMode[config_regs_pkg::SM_UART1_FAST];
  assign uart2HighSpeed = q.serialMode[config_regs_pkg::SM_UART2_FAST];

  // test bits are visible but steer nothing here
  assign testBitsOut = q.testBits;

  // clock generator and loopback controls
  assign pllGainDouble = q.clockGen[config_regs_pkg::CG_PLL_GAIN_DOUBLE];
  assign pllHalt = q.clockGen[config_regs_pkg::CG_PLL_HALT];
  assign serialClkDividerHalt = q.clockGen[config_regs_pkg::CG_DIVIDER_HALT];
  assign pllInput24m = q.clockGen[config_regs_pkg::CG_PLL_INPUT_24M];
  assign irTestRoute = q.clockGen[config_regs_pkg::CG_IR_TEST];
  assign irLoopback = q.loopback[config_regs_pkg::LB_IR_LOOPBACK];
  assign fdcTimeoutTest = q.loopback[config_regs_pkg::LB_FDC_TIMEOUT_TEST];
  assign uartClkEn = q.divPulse;

  // ********************************************
  // checks
  // ********************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  logic [7:0] idxVal;
  assign idxVal = q.idx;

  no_access_a: assert property (
    !cfgMode |=> $stable(q.serialMode) && $stable(q.clockGen)
                 && $stable(q.rateTable) && !rdValid)
    else $error("register changed or read outside config mode");

  rate_map_a: assert property (
    cfgMode && dataWe && idxVal == config_regs_pkg::IDX_RATE_TABLE
    |=> driveZeroRate == $past(wrData[1:0])
        && driveThreeRate == $past(wrData[7:6]))
    else $error("drive rate pairs mapped wrongly");

  reset_zero_a: assert property (
    $rose(rst_n) |-> q.serialMode == 8'h00 && q.clockGen == 8'h00
                     && q.rateTable == 8'h00 && q.testBits == 8'h00)
    else $error("registers not zero after reset");

  rx_invert_a: assert property (
    ##1 uart2RxCore == ($past(uart2RxPin)
                        ^ $past(q.serialMode[0])))
    else $error("receive polarity wrong");

  tx_invert_a: assert property (
    !irTestRoute |=> serialOutPin == ($past(uart2TxCore)
                                      ^ $past(q.serialMode[1])))
    else $error("transmit polarity wrong");

  ident_read_a: assert property (
    cfgMode && dataRe && idxVal == config_regs_pkg::IDX_PART_IDENT
    |=> rdValid && rdData == config_regs_pkg::PART_IDENT_CODE)
    else $error("part code read wrong");

  rev_read_a: assert property (
    cfgMode && dataRe && idxVal == config_regs_pkg::IDX_SILICON_REV
    |=> rdValid && rdData == config_regs_pkg::SILICON_REV_CODE)
    else $error("revision read wrong");

  clk_low_zero_a: assert property (
    cfgMode && dataRe && idxVal == config_regs_pkg::IDX_CLOCK_GEN
    |=> rdData[2:0] == 3'h0)
    else $error("clock control low bits not zero");

  ro_write_a: assert property (
    cfgMode && dataWe && !indexWe
    && idxVal == config_regs_pkg::IDX_PART_IDENT
    |=> $stable(q.rateTable) && $stable(q.serialMode)
        && $stable(q.clockGen) && $stable(q.testBits))
    else $error("write to read-only register changed state");

  div_halt_a: assert property (
    serialClkDividerHalt |=> !uartClkEn && q.divCnt == 4'h0)
    else $error("divider ran while halted");

  div_gap_a: assert property (
    uartClkEn |=> (!uartClkEn) [*8])
    else $error("divider enable too frequent");

  ir_route_a: assert property (
    irTestRoute |=> serialOutPin == ($past(uart2RxPin)
                                     & $past(uart2TxCore)))
    else $error("ir test routing wrong");

  // index and read strobe: nothing moves without an accepted access
  index_gate_a: assert property (
    !(cfgMode && indexWe) |=> $stable(q.idx))
    else $error("index moved without a config index write");

  index_load_a: assert property (
    cfgMode && indexWe |=> indexValue == $past(wrData))
    else $error("index write not taken");

  read_pulse_a: assert property (
    !(cfgMode && dataRe) |=> !rdValid)
    else $error("read valid without an accepted read");

  read_hold_a: assert property (
    !(cfgMode && dataRe) |=> $stable(rdData))
    else $error("read data moved without a read");

  // readback is compared with the pins of the previous cycle, so a write
  // in the same cycle cannot make this fire
  rate_read_a: assert property (
    cfgMode && dataRe && idxVal == config_regs_pkg::IDX_RATE_TABLE
    |=> rdData == $past({driveThreeRate, driveTwoRate, driveOneRate,
                         driveZeroRate}))
    else $error("rate table readback wrong");

  // field placement of the serial mode register
  duplex_map_a: assert property (
    cfgMode && dataWe && idxVal == config_regs_pkg::IDX_SERIAL_MODE
    |=> uart2HalfDuplex == $past(wrData[2]))
    else $error("duplex bit mapped wrongly");

  mode_map_a: assert property (
    cfgMode && dataWe && idxVal == config_regs_pkg::IDX_SERIAL_MODE
    |=> uart2Mode == $past(wrData[5:3]))
    else $error("port 2 mode field mapped wrongly");

  speed_map_a: assert property (
    cfgMode && dataWe && idxVal == config_regs_pkg::IDX_SERIAL_MODE
    |=> uart1HighSpeed == $past(wrData[6])
        && uart2HighSpeed == $past(wrData[7]))
    else $error("speed bits mapped wrongly");

  reserved_mode_a: assert property (
    uart2Mode[2] || uart2Mode == 3'h3 |-> !uart2ModeIrda && !uart2ModeAsk)
    else $error("reserved mode raised an infrared flag");

  // clock generator and loopback fields
  gain_map_a: assert property (
    cfgMode && dataWe && idxVal == config_regs_pkg::IDX_CLOCK_GEN
    |=> pllGainDouble == $past(wrData[3]))
    else $error("loop gain bit mapped wrongly");

  halt_map_a: assert property (
    cfgMode && dataWe && idxVal == config_regs_pkg::IDX_CLOCK_GEN
    |=> pllHalt == $past(wrData[4]))
    else $error("loop stop bit mapped wrongly");

  pll_input_a: assert property (
    cfgMode && dataWe && idxVal == config_regs_pkg::IDX_CLOCK_GEN
    |=> pllInput24m == $past(wrData[6]))
    else $error("loop input select mapped wrongly");

  loop_read_a: assert property (
    cfgMode && dataRe && idxVal == config_regs_pkg::IDX_LOOPBACK
    |=> rdData[7:2] == 6'h00)
    else $error("loopback reserved bits not zero");

  // reset loading is checked across the reset itself, so the default
  // disable is switched off for these two
  mode_clear_a: assert property (
    disable iff (1'h0) !rst_n
    |=> q.serialMode == config_regs_pkg::RESET_ZERO)
    else $error("serial mode not cleared by reset");

  zero_load_a: assert property (
    disable iff (1'h0) !rst_n
    |=> q.rateTable == config_regs_pkg::RESET_ZERO
        && q.testBits == config_regs_pkg::RESET_ZERO
        && q.clockGen == config_regs_pkg::RESET_ZERO
        && q.loopback == config_regs_pkg::RESET_ZERO)
    else $error("writable registers not zero after reset");

  cover_mode_write_c: cover property (
    cfgMode && dataWe && idxVal == config_regs_pkg::IDX_SERIAL_MODE);
  cover_ident_read_c: cover property (
    cfgMode && dataRe && idxVal == config_regs_pkg::IDX_PART_IDENT);
  cover_halt_c: cover property ($rose(serialClkDividerHalt));
  cover_ir_test_c: cover property ($rose(irTestRoute));
  cover_gate_c: cover property (!cfgMode && dataWe);

endmodule
`default_nettype wire

// ---- testbench/test_config_regs_uart_pll_id.sv ----
`timescale 1ns/1ps
`default_nettype none
// ***************************************************
// compare helper: counts every check, reports misses
// ***************************************************
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin errorCnt++; \
  $display("ERROR %s expected %0h seen %0h", nm, e, g); end end
module test_config_regs_uart_pll_id;
  logic       clk = 1'b0, rst_n = 1'b0, cfgMode = 1'b0, indexWe = 1'b0;
  logic       dataWe = 1'b0, dataRe = 1'b0, uart2RxPin = 1'b0;
  logic       uart2TxCore = 1'b0, serialDivBy13 = 1'b0;
  logic [7:0] wrData = 8'h00, rdData, indexValue, testBitsOut, v;
  logic [1:0] driveZeroRate, driveOneRate, driveTwoRate, driveThreeRate;
  logic [2:0] uart2Mode;
  logic       rdValid, uart2RxCore, serialOutPin, uart2HalfDuplex;
  logic       uart2ModeIrda, uart2ModeAsk, uart1HighSpeed, uart2HighSpeed;
  logic       pllGainDouble, pllHalt, serialClkDividerHalt, pllInput24m;
  logic       irTestRoute, irLoopback, fdcTimeoutTest, uartClkEn;
  int         errorCnt = 0, comparisons = 0, n;
  config_regs_uart_pll_id DUT (.clk, .rst_n, .cfgMode, .indexWe, .dataWe,
    .dataRe, .wrData, .uart2RxPin, .uart2TxCore, .serialDivBy13, .rdData,
    .rdValid, .indexValue, .driveZeroRate, .driveOneRate, .driveTwoRate,
    .driveThreeRate, .uart2RxCore, .serialOutPin, .uart2HalfDuplex,
    .uart2Mode, .uart2ModeIrda, .uart2ModeAsk, .uart1HighSpeed,
    .uart2HighSpeed, .testBitsOut, .pllGainDouble, .pllHalt,
    .serialClkDividerHalt, .pllInput24m, .irTestRoute, .irLoopback,
    .fdcTimeoutTest, .uartClkEn);
  // 250 MHz clock
  always #2 clk = ~clk;
  // ***************************************************
  // bus tasks: inputs move 1 ns after the rising edge
  // ***************************************************
  task automatic cyc();
    @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    cfgMode = 1'b1; indexWe = 1'b1; wrData = idx; cyc();
    indexWe = 1'b0; dataWe = 1'b1; wrData = d; cyc();
    dataWe = 1'b0;
  endtask
  task automatic rd(input logic [7:0] idx, output logic [7:0] r);
    cfgMode = 1'b1; indexWe = 1'b1; wrData = idx; cyc();
    indexWe = 1'b0; dataRe = 1'b1; cyc();
    dataRe = 1'b0;
    `CHK("rdValid", 1'b1, rdValid)
    r = rdData;
  endtask
  // ***************************************************
  // scenarios
  // ***************************************************
  task automatic tReset();
    logic [7:0] e;
    for (int i = 0; i < 8; i++) begin
      e = (i == 2) ? config_regs_pkg::PART_IDENT_CODE :
          (i == 3) ? config_regs_pkg::SILICON_REV_CODE : 8'h00;
      rd(8'h0b + 8'(i), v);
      `CHK("reset read", e, v)
    end
    `CHK("testBitsOut", 8'h00, testBitsOut)
  endtask
  task automatic tRate();
    wr(8'h0b, 8'he4);
    `CHK("drive0", 2'h0, driveZeroRate)
    `CHK("drive1", 2'h1, driveOneRate)
    `CHK("drive2", 2'h2, driveTwoRate)
    `CHK("drive3", 2'h3, driveThreeRate)
  endtask
  task automatic tSerial();
    uart2RxPin = 1'b1; uart2TxCore = 1'b1;
    wr(8'h0c, 8'h47); cyc();
    `CHK("rxCore inv", 1'b0, uart2RxCore)
    `CHK("txOut inv", 1'b0, serialOutPin)
    `CHK("halfDuplex", 1'b1, uart2HalfDuplex)
    `CHK("speeds", 2'b01, {uart2HighSpeed, uart1HighSpeed})
    wr(8'h0c, 8'h80); cyc();
    `CHK("rxCore", 1'b1, uart2RxCore)
    `CHK("txOut", 1'b1, serialOutPin)
    `CHK("fullDuplex", 1'b0, uart2HalfDuplex)
    `CHK("speeds", 2'b10, {uart2HighSpeed, uart1HighSpeed})
    // every mode code, reserved ones included
    for (int m = 0; m < 8; m++) begin
      wr(8'h0c, {2'b00, 3'(m), 3'b000});
      `CHK("mode", 3'(m), uart2Mode)
      `CHK("irFlags", {m == 1, m == 2}, {uart2ModeIrda, uart2ModeAsk})
    end
  endtask
  task automatic tReadOnly();
    wr(8'h0d, 8'hff); wr(8'h0e, 8'h00);
    rd(8'h0d, v);
    `CHK("part code", config_regs_pkg::PART_IDENT_CODE, v)
    rd(8'h0e, v);
    `CHK("revision", config_regs_pkg::SILICON_REV_CODE, v)
    wr(8'h10, 8'hff); rd(8'h10, v);
    `CHK("clock ctrl", 8'hf8, v)
    // one control bit at a time catches swapped outputs
    for (int b = 3; b < 8; b++) begin
      wr(8'h10, 8'h01 << b);
      `CHK("clkBits", 5'h01 << (b - 3), {irTestRoute, pllInput24m,
        serialClkDividerHalt, pllHalt, pllGainDouble})
    end
    uart2RxPin = 1'b1; uart2TxCore = 1'b0; cyc();
    `CHK("irTest out", 1'b0, serialOutPin)
    uart2TxCore = 1'b1; cyc(); cyc();
    `CHK("irTest out", 1'b1, serialOutPin)
    wr(8'h11, 8'hff); rd(8'h11, v);
    `CHK("loopback reg", 8'h03, v)
    `CHK("loopBits", 2'b11, {fdcTimeoutTest, irLoopback})
    wr(8'h0f, 8'h00);
    `CHK("testBitsOut", 8'h00, testBitsOut)
  endtask
  task automatic tGate();
    wr(8'h0c, 8'h00);
    cfgMode = 1'b0; indexWe = 1'b1; wrData = 8'h0b; cyc();
    indexWe = 1'b0; dataWe = 1'b1; wrData = 8'hff; cyc();
    dataWe = 1'b0; dataRe = 1'b1; cyc();
    dataRe = 1'b0;
    `CHK("rdValid gated", 1'b0, rdValid)
    `CHK("index gated", 8'h0c, indexValue)
    `CHK("mode gated", 1'b0, uart2HalfDuplex)
  endtask
  // period between divider pulses, bounded wait
  task automatic period(output int p);
    p = 0;
    do begin cyc(); p++; end while (uartClkEn !== 1'b1 && p < 40);
  endtask
  task automatic tDivider();
    wr(8'h10, 8'h00); serialDivBy13 = 1'b0;
    period(n); period(n);
    `CHK("div12 period", 12, n)
    serialDivBy13 = 1'b1; period(n);
    `CHK("div13 period", 13, n)
    wr(8'h10, 8'h20); n = 0;
    // a halted divider must stay silent
    repeat (30) begin cyc(); n += int'(uartClkEn !== 1'b0); end
    `CHK("halted pulses", 0, n)
  endtask
  task automatic tMidReset();
    wr(8'h0c, 8'hff); wr(8'h0b, 8'hff);
    rst_n = 1'b0; cyc(); rst_n = 1'b1;
    rd(8'h0c, v);
    `CHK("mode after reset", 8'h00, v)
    rd(8'h0b, v);
    `CHK("rate after reset", 8'h00, v)
  endtask
  // ***************************************************
  // verdict
  // ***************************************************
  task automatic endOfTest();
    $display("checks %0d errors %0d", comparisons, errorCnt);
    if (errorCnt == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // watchdog well beyond the roughly 160 cycles the run needs
  initial begin
    #40000;
    errorCnt++;
    endOfTest();
  end
  initial begin
    repeat (8) cyc();
    rst_n = 1'b1;
    tReset();
    tRate();
    tSerial();
    tReadOnly();
    tGate();
    tDivider();
    tMidReset();
    endOfTest();
  end
endmodule
`default_nettype wire
